// [verilog/bgc_gate_ctrl.sv]
/*
  Top of the three-phase gate control and protection logic: input
  synchronisers, configuration decode, latched faults, enable-cycle clearing,
  open-drain fault output and warning status.
  Assumes all pin inputs are asynchronous to core_clk_i.
*/
//
// Function
// - Each gate input high drives its gate on; undriven inputs read as off.
// - Any fault or low chip enable forces all six gate outputs low.
// - Both switches of one half-bridge commanded on turns both off.
// - Dead time before turn-on, 250 ns to 2000 ns in 250 ns steps.
// - Blanking of 500 ns, 1, 2 or 4 us ignores switching current spikes.
// - Blanking starts only after the dead time of that event expires.
// - Bias-low counted only while driving; past qualification the driver refuses turn-on.
// - Bias-low fault latches, drives fault output, clears on enable low-then-high.
// - Drain-source short after turn-on kills all gates and latches a fault.
// - High side sensed supply to terminal, low side terminal to ground.
// - Two-bit short threshold select plus separate short detection enable.
// - Bias-low guard enable; when off no bias-low fault is raised.
// - Bias-low qualification includes any blanking period in progress.
// - Fault output pulls low on any fault and on current-limit comparator.
// - Listed device faults also drive the fault output.
// - Warnings go to status only and never drive the fault output.
`timescale 1ns/10ps
module bgc_gate_ctrl #(
  parameter int unsigned PHASES = 3
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic chip_enable_i,
  input wire logic [PHASES-1:0] gate_cmd_high_i,
  input wire logic [PHASES-1:0] gate_cmd_low_i,
  input wire logic [2:0] dead_time_select_i,
  input wire logic [1:0] blanking_select_i,
  input wire logic [1:0] short_threshold_select_i,
  input wire logic switch_short_detect_enable_i,
  input wire logic gate_bias_guard_enable_i,
  input wire logic [PHASES-1:0] desat_high_i,
  input wire logic [PHASES-1:0] desat_low_i,
  input wire logic [PHASES-1:0] bias_low_i,
  input wire logic current_limit_i,
  input wire logic [bgc_pkg::NUM_EXT_FAULT-1:0] ext_fault_i,
  input wire logic [bgc_pkg::NUM_WARN-1:0] warn_i,
  output logic high_gate_out_a_o,
  output logic high_gate_out_b_o,
  output logic high_gate_out_c_o,
  output logic low_gate_out_a_o,
  output logic low_gate_out_b_o,
  output logic low_gate_out_c_o,
  output logic fault_flag_out_o,
  output logic fault_flag_oe_o,
  output logic [1:0] short_threshold_o,
  output logic switch_uv_fault_o,
  output logic switch_short_fault_o,
  output logic [bgc_pkg::NUM_WARN-1:0] warn_status_o
);
  localparam int unsigned SYN_W = 3 * PHASES + 3 + bgc_pkg::NUM_EXT_FAULT + bgc_pkg::NUM_WARN;

  logic [SYN_W-1:0] syn1_reg;
  logic [SYN_W-1:0] syn2_reg;
  logic [PHASES-1:0] cmd_high;
  logic [PHASES-1:0] cmd_low;
  logic [PHASES-1:0] dsh;
  logic [PHASES-1:0] dsl;
  logic [PHASES-1:0] bl;
  logic ce_s;
  logic ilim_s;
  logic cfg_s;
  logic [bgc_pkg::NUM_EXT_FAULT-1:0] ext_s;
  logic [bgc_pkg::NUM_WARN-1:0] warn_s;
  logic ce_prev_reg;
  logic [7:0] ce_low_cnt_reg;
  logic ce_clear;
  logic uv_fault_reg;
  logic sc_fault_reg;
  logic kill;
  logic [PHASES-1:0] gh;
  logic [PHASES-1:0] gl;
  logic [PHASES-1:0] short_evt;
  logic [PHASES-1:0] uv_evt;
  logic [7:0] dead_cyc;
  logic [7:0] blank_cyc;

  // Pins pass two flops before use; undriven pins are pulled low outside
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      syn1_reg <= '0;
      syn2_reg <= '0;
    end else begin
      syn1_reg <= {warn_i, ext_fault_i, switch_short_detect_enable_i, current_limit_i,
                   chip_enable_i, bias_low_i, desat_low_i, desat_high_i};
      syn2_reg <= syn1_reg;
    end
  end

  assign dsh = syn2_reg[PHASES-1:0];
  assign dsl = syn2_reg[2*PHASES-1:PHASES];
  assign bl = syn2_reg[3*PHASES-1:2*PHASES];
  assign ce_s = syn2_reg[3*PHASES];
  assign ilim_s = syn2_reg[3*PHASES+1];
  assign cfg_s = syn2_reg[3*PHASES+2];
  assign ext_s = syn2_reg[3*PHASES+3 +: bgc_pkg::NUM_EXT_FAULT];
  assign warn_s = syn2_reg[3*PHASES+3+bgc_pkg::NUM_EXT_FAULT +: bgc_pkg::NUM_WARN];

  // Gate commands get their own pair of flops so all six shift together
  logic [2*PHASES-1:0] cmd1_reg;
  logic [2*PHASES-1:0] cmd2_reg;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd1_reg <= '0;
      cmd2_reg <= '0;
    end else begin
      cmd1_reg <= {gate_cmd_low_i, gate_cmd_high_i};
      cmd2_reg <= cmd1_reg;
    end
  end
  assign cmd_high = cmd2_reg[PHASES-1:0];
  assign cmd_low = cmd2_reg[2*PHASES-1:PHASES];

  // Configuration pins are asynchronous as well, so they pass two flops too;
  // a dead time or blanking change only applies when that interval next starts
  logic [2:0] dt_raw_reg;
  logic [1:0] bt_raw_reg;
  logic [1:0] thr_raw_reg;
  logic uv_en_raw_reg;
  logic [2:0] dt_sel_reg;
  logic [1:0] bt_sel_reg;
  logic [1:0] thr_reg;
  logic uv_en_reg;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dt_raw_reg <= bgc_pkg::DT_SEL_RST;
      bt_raw_reg <= bgc_pkg::BT_SEL_RST;
      thr_raw_reg <= bgc_pkg::SC_THR_RST;
      uv_en_raw_reg <= bgc_pkg::UV_EN_RST;
    end else begin
      dt_raw_reg <= dead_time_select_i;
      bt_raw_reg <= blanking_select_i;
      thr_raw_reg <= short_threshold_select_i;
      uv_en_raw_reg <= gate_bias_guard_enable_i;
    end
  end

  // Second stage; only these are read by the timing and fault logic
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dt_sel_reg <= bgc_pkg::DT_SEL_RST;
      bt_sel_reg <= bgc_pkg::BT_SEL_RST;
      thr_reg <= bgc_pkg::SC_THR_RST;
      uv_en_reg <= bgc_pkg::UV_EN_RST;
    end else begin
      dt_sel_reg <= dt_raw_reg;
      bt_sel_reg <= bt_raw_reg;
      thr_reg <= thr_raw_reg;
      uv_en_reg <= uv_en_raw_reg;
    end
  end
  assign dead_cyc = bgc_pkg::bgc_dead_cyc(dt_sel_reg);
  assign blank_cyc = bgc_pkg::bgc_blank_cyc(bt_sel_reg);

  // Chip enable low then high clears the latched faults
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ce_prev_reg <= 1'b0;
      ce_low_cnt_reg <= 8'h00;
    end else begin
      ce_prev_reg <= ce_s;
      if (ce_s) begin
        ce_low_cnt_reg <= 8'h00;
      end else if (ce_low_cnt_reg != 8'hff) begin
        ce_low_cnt_reg <= ce_low_cnt_reg + 8'h01;
      end
    end
  end
  assign ce_clear = ce_s & ~ce_prev_reg & (ce_low_cnt_reg >= 8'(bgc_pkg::CE_CLR_CYC));

  // Latched faults; a new event in the clearing cycle wins
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_fault_reg <= 1'b0;
    end else begin
      uv_fault_reg <= (|uv_evt) | (uv_fault_reg & ~ce_clear);
    end
  end

  // A short still present at the clearing edge simply latches again
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sc_fault_reg <= 1'b0;
    end else begin
      sc_fault_reg <= (|short_evt) | (sc_fault_reg & ~ce_clear);
    end
  end

  assign kill = ~ce_s | uv_fault_reg | sc_fault_reg | (|uv_evt) | (|short_evt) | (|ext_s);

  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_ph
      bgc_half_bridge u_hb (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .cmd_high_i(cmd_high[p]),
        .cmd_low_i(cmd_low[p]),
        .kill_i(kill),
        .dead_cyc_i(dead_cyc),
        .blank_cyc_i(blank_cyc),
        .desat_high_i(dsh[p]),
        .desat_low_i(dsl[p]),
        .bias_low_i(bl[p]),
        .uv_en_i(uv_en_reg),
        .sc_en_i(cfg_s),
        .gate_high_o(gh[p]),
        .gate_low_o(gl[p]),
        .short_evt_o(short_evt[p]),
        .uv_evt_o(uv_evt[p])
      );
    end
  endgenerate

  // Outputs re-registered so the kill path also acts within one edge
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_gate_out_a_o <= 1'b0;
      high_gate_out_b_o <= 1'b0;
      high_gate_out_c_o <= 1'b0;
      low_gate_out_a_o <= 1'b0;
      low_gate_out_b_o <= 1'b0;
      low_gate_out_c_o <= 1'b0;
    end else begin
      high_gate_out_a_o <= gh[0] & ~kill;
      high_gate_out_b_o <= gh[1] & ~kill;
      high_gate_out_c_o <= gh[2] & ~kill;
      low_gate_out_a_o <= gl[0] & ~kill;
      low_gate_out_b_o <= gl[1] & ~kill;
      low_gate_out_c_o <= gl[2] & ~kill;
    end
  end

  // Open drain: pin driven low (enable high) on fault or current limit, never warnings
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_flag_out_o <= 1'b0;
      fault_flag_oe_o <= 1'b0;
    end else begin
      fault_flag_out_o <= 1'b0;
      fault_flag_oe_o <= uv_fault_reg | sc_fault_reg | (|ext_s) | ilim_s;
    end
  end

  // Latched fault status for the host
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      switch_uv_fault_o <= 1'b0;
      switch_short_fault_o <= 1'b0;
    end else begin
      switch_uv_fault_o <= uv_fault_reg;
      switch_short_fault_o <= sc_fault_reg;
    end
  end

  // Threshold echo for the comparator; warnings are status only
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      short_threshold_o <= bgc_pkg::SC_THR_RST;
      warn_status_o <= '0;
    end else begin
      short_threshold_o <= thr_reg;
      warn_status_o <= warn_s;
    end
  end
endmodule

// [inc/bgc_pkg.sv]
/*
  Package for the gate control and protection block: configuration encodings,
  reset values and timing constants.
  Assumes a 10 MHz core clock.
*/
package bgc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DT_STEP_NS = 250;
  localparam int unsigned DT_MIN_NS = 250;
  localparam int unsigned DT_MAX_NS = 2000;
  localparam int unsigned BT_MIN_NS = 500;
  localparam int unsigned BT_MAX_NS = 4000;
  localparam int unsigned UV_QUAL_NS = 10000;
  localparam int unsigned CE_CLR_NS = 100;
  localparam int unsigned CNT_W = 8;
  localparam logic [2:0] DT_SEL_RST = 3'h7;
  localparam logic [1:0] BT_SEL_RST = 2'h3;
  localparam logic [1:0] SC_THR_RST = 2'h0;
  localparam logic UV_EN_RST = 1'b1;
  localparam int unsigned UV_QUAL_CYC = UV_QUAL_NS / CLK_PERIOD_NS;
  localparam int unsigned CE_CLR_CYC = (CE_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NUM_WARN = 4;
  localparam int unsigned NUM_EXT_FAULT = 6;

  typedef enum logic [1:0] {
    BGC_PH_IDLE,
    BGC_PH_DEAD,
    BGC_PH_BLANK,
    BGC_PH_ON
  } bgc_phase_t;

  // Dead time in cycles: 250 ns steps, rounded up
  function automatic logic [7:0] bgc_dead_cyc(input logic [2:0] sel);
    int unsigned ns;
    ns = DT_MIN_NS + int'(sel) * DT_STEP_NS;
    bgc_dead_cyc = 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // Blanking in cycles: 500 ns doubling per step
  function automatic logic [7:0] bgc_blank_cyc(input logic [1:0] sel);
    int unsigned ns;
    ns = BT_MIN_NS << sel;
    bgc_blank_cyc = 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction
endpackage

// [verilog/bgc_half_bridge.sv]
/*
  One half-bridge gate channel: cross-conduction block, dead time, blanking
  and the per-switch short and bias-low qualification.
  Assumes synchronised inputs and a common fault/enable kill from the top.
*/
`timescale 1ns/10ps
module bgc_half_bridge (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_high_i,
  input wire logic cmd_low_i,
  input wire logic kill_i,
  input wire logic [7:0] dead_cyc_i,
  input wire logic [7:0] blank_cyc_i,
  input wire logic desat_high_i,
  input wire logic desat_low_i,
  input wire logic bias_low_i,
  input wire logic uv_en_i,
  input wire logic sc_en_i,
  output logic gate_high_o,
  output logic gate_low_o,
  output logic short_evt_o,
  output logic uv_evt_o
);
  logic want_high;
  logic want_low;
  logic sel_high_reg;
  logic [7:0] cnt_reg;
  logic [15:0] uv_cnt_reg;
  bgc_pkg::bgc_phase_t phase_reg;

  // Both commanded on: both stay off
  assign want_high = cmd_high_i & ~cmd_low_i;
  assign want_low = cmd_low_i & ~cmd_high_i;

  // Each off-to-on command restarts dead time then blanking
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg <= bgc_pkg::BGC_PH_IDLE;
      cnt_reg <= 8'h00;
      sel_high_reg <= 1'b0;
    end else if (kill_i || !(want_high || want_low) || (want_high != sel_high_reg)) begin
      sel_high_reg <= want_high;
      cnt_reg <= dead_cyc_i;
      phase_reg <= (want_high || want_low) && !kill_i ? bgc_pkg::BGC_PH_DEAD
                                                      : bgc_pkg::BGC_PH_IDLE;
    end else begin
      case (phase_reg)
        bgc_pkg::BGC_PH_IDLE: begin
          cnt_reg <= dead_cyc_i;
          phase_reg <= bgc_pkg::BGC_PH_DEAD;
        end
        bgc_pkg::BGC_PH_DEAD: begin
          if (cnt_reg <= 8'h01) begin
            cnt_reg <= blank_cyc_i;
            phase_reg <= bgc_pkg::BGC_PH_BLANK;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        bgc_pkg::BGC_PH_BLANK: begin
          if (cnt_reg <= 8'h01) begin
            phase_reg <= bgc_pkg::BGC_PH_ON;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        bgc_pkg::BGC_PH_ON: phase_reg <= bgc_pkg::BGC_PH_ON;
        default: phase_reg <= bgc_pkg::BGC_PH_IDLE;
      endcase
    end
  end

  // Gate on only after dead time; refused while a bias-low fault is pending
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gate_high_o <= 1'b0;
      gate_low_o <= 1'b0;
    end else begin
      gate_high_o <= ~kill_i & want_high & sel_high_reg &
                     (phase_reg == bgc_pkg::BGC_PH_BLANK || phase_reg == bgc_pkg::BGC_PH_ON);
      gate_low_o <= ~kill_i & want_low & ~sel_high_reg &
                    (phase_reg == bgc_pkg::BGC_PH_BLANK || phase_reg == bgc_pkg::BGC_PH_ON);
    end
  end

  // Short sensed per driven switch, ignored during blanking
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      short_evt_o <= 1'b0;
    end else begin
      short_evt_o <= sc_en_i && phase_reg == bgc_pkg::BGC_PH_ON &&
                     ((gate_high_o && desat_high_i) || (gate_low_o && desat_low_i));
    end
  end

  // Bias-low counted only while driving; the count includes the blanking span
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_cnt_reg <= 16'h0000;
      uv_evt_o <= 1'b0;
    end else begin
      if (uv_en_i && bias_low_i && (gate_high_o || gate_low_o)) begin
        if (uv_cnt_reg < 16'(bgc_pkg::UV_QUAL_CYC)) begin
          uv_cnt_reg <= uv_cnt_reg + 16'h0001;
        end
      end else begin
        uv_cnt_reg <= 16'h0000;
      end
      uv_evt_o <= uv_en_i && uv_cnt_reg >= 16'(bgc_pkg::UV_QUAL_CYC);
    end
  end
endmodule

// [bench/bgc_gate_ctrl_chk.sv]
/*
  Checker for the gate control top: kill paths, shoot-through, dead time, fault pin.
  Assumes it is bound to every bgc_gate_ctrl instance.
*/
`timescale 1ns/10ps
module bgc_gate_ctrl_chk #(
  parameter int unsigned PHASES = 3
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic chip_enable_i,
  input wire logic [PHASES-1:0] gate_cmd_high_i,
  input wire logic [1:0] short_threshold_select_i,
  input wire logic switch_short_detect_enable_i,
  input wire logic gate_bias_guard_enable_i,
  input wire logic current_limit_i,
  input wire logic [bgc_pkg::NUM_EXT_FAULT-1:0] ext_fault_i,
  input wire logic high_gate_out_a_o,
  input wire logic high_gate_out_b_o,
  input wire logic high_gate_out_c_o,
  input wire logic low_gate_out_a_o,
  input wire logic low_gate_out_b_o,
  input wire logic low_gate_out_c_o,
  input wire logic fault_flag_out_o,
  input wire logic fault_flag_oe_o,
  input wire logic [1:0] short_threshold_o,
  input wire logic switch_uv_fault_o,
  input wire logic switch_short_fault_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [5:0] gates;
  assign gates = {low_gate_out_c_o, low_gate_out_b_o, low_gate_out_a_o,
    high_gate_out_c_o, high_gate_out_b_o, high_gate_out_a_o};
  // Kill path is sync plus output flop, so four cycles of cause are enough
  AST_CE_OFF: assert property (!chip_enable_i [*4] |-> gates == 6'h00)
    else $error("gates on while disabled");
  AST_NO_SHOOT: assert property ((gates[2:0] & gates[5:3]) == 3'h0)
    else $error("both switches of a phase on");
  AST_DEAD_MIN: assert property ($rose(high_gate_out_a_o) |->
    $past(gate_cmd_high_i[0], 4) && $past(gate_cmd_high_i[0], 2)) else $error("dead time short");
  AST_BBM: assert property ($rose(low_gate_out_a_o) |->
    !$past(high_gate_out_a_o, 1) && !$past(high_gate_out_a_o, 2)) else $error("make before break");
  AST_PIN_LOW: assert property (fault_flag_out_o == 1'b0)
    else $error("fault pin driven high");
  AST_ILIM: assert property (current_limit_i [*4] |-> fault_flag_oe_o)
    else $error("current limit not on fault pin");
  AST_EXT_KILL: assert property ((ext_fault_i != '0) [*4] |-> fault_flag_oe_o && gates == 6'h00)
    else $error("device fault did not kill gates");
  AST_LATCH_KILL: assert property ((switch_uv_fault_o || switch_short_fault_o) [*2] |->
    gates == 6'h00 && fault_flag_oe_o) else $error("latched fault left gates on");
  AST_QUIET: assert property ((!current_limit_i && ext_fault_i == '0 && !switch_uv_fault_o &&
    !switch_short_fault_o) [*4] |-> !fault_flag_oe_o) else $error("fault pin without fault");
  AST_THR_ECHO: assert property ($stable(short_threshold_select_i) [*3] |->
    short_threshold_o == short_threshold_select_i) else $error("threshold not echoed");
  AST_SC_OFF: assert property (!switch_short_detect_enable_i [*4] |-> !$rose(switch_short_fault_o))
    else $error("short fault while detection off");
  AST_UV_OFF: assert property (!gate_bias_guard_enable_i [*4] |-> !$rose(switch_uv_fault_o))
    else $error("bias fault while guard off");
  cover property ($rose(switch_short_fault_o));
  cover property ($rose(switch_uv_fault_o));
  cover property ($rose(low_gate_out_a_o));
endmodule
bind bgc_gate_ctrl bgc_gate_ctrl_chk #(.PHASES(PHASES)) i_chk (.core_clk_i(core_clk_i),
  .rstn_i(rstn_i), .chip_enable_i(chip_enable_i), .gate_cmd_high_i(gate_cmd_high_i),
  .short_threshold_select_i(short_threshold_select_i), .current_limit_i(current_limit_i),
  .switch_short_detect_enable_i(switch_short_detect_enable_i), .ext_fault_i(ext_fault_i),
  .gate_bias_guard_enable_i(gate_bias_guard_enable_i), .high_gate_out_a_o(high_gate_out_a_o),
  .high_gate_out_b_o(high_gate_out_b_o), .high_gate_out_c_o(high_gate_out_c_o),
  .low_gate_out_a_o(low_gate_out_a_o), .low_gate_out_b_o(low_gate_out_b_o),
  .low_gate_out_c_o(low_gate_out_c_o), .fault_flag_out_o(fault_flag_out_o),
  .fault_flag_oe_o(fault_flag_oe_o), .short_threshold_o(short_threshold_o),
  .switch_uv_fault_o(switch_uv_fault_o), .switch_short_fault_o(switch_short_fault_o));

// [bench/bgc_host_model.sv]
/*
  Host model: six gate commands, raw from the bench or bootstrap, lock and ramp.
  Assumes the bench changes mode_i only between sequences.
*/
`timescale 1ns/10ps
module bgc_host_model #(
  parameter int RAMP_START = 40
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i,
  input wire logic [5:0] raw_i,
  output logic [2:0] cmd_high_o,
  output logic [2:0] cmd_low_o
);
  // Commutation states as {low c b a, high c b a}
  localparam logic [5:0] STEPS [6] = '{6'h21, 6'h22, 6'h0a, 6'h0c, 6'h14, 6'h11};
  logic [2:0] idx_reg;
  logic [5:0] out_reg;
  int per_reg;
  int cnt_reg;
  assign {cmd_low_o, cmd_high_o} = out_reg;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_reg <= 6'h00;
      idx_reg <= 3'h0;
      per_reg <= RAMP_START;
      cnt_reg <= 0;
    end else begin
      case (mode_i)
        2'h1: out_reg <= 6'h38;
        2'h2: out_reg <= 6'h15;
        2'h3: begin
          // At floor speed the loop counts as locked (no back-EMF modelled here);
          // the high sides are then chopped at a fixed rate, low sides stay on
          if (per_reg <= 25 && cnt_reg > per_reg / 2) begin
            out_reg <= STEPS[idx_reg] & 6'h38;
          end else begin
            out_reg <= STEPS[idx_reg];
          end
          if (cnt_reg >= per_reg) begin
            cnt_reg <= 0;
            idx_reg <= (idx_reg == 3'h5) ? 3'h0 : idx_reg + 3'h1;
            // Linear speed-up, floored so each state outlasts the dead time
            if (per_reg > 25) per_reg <= per_reg - 1;
          end else cnt_reg <= cnt_reg + 1;
        end
        // Raw commands may be illegal on purpose, for the refusal tests
        default: out_reg <= raw_i;
      endcase
    end
  end
endmodule

// [bench/tb_bgc_gate_ctrl.sv]
/*
  Bench for the gate control block, host model on the command pins.
  Assumes outputs settle before the falling edge, where they are sampled.
*/
`timescale 1ns/10ps
module tb_bgc_gate_ctrl;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, cl = 1'b0, sc_en = 1'b1, uv_en = 1'b1, fo, oe, uvf, scf;
  logic [1:0] mode = 2'h0, bts = 2'h3, thr = 2'h0, thr_o;
  logic [2:0] dts = 3'h7, dh = 3'h0, dl = 3'h0, bl = 3'h0, ch, cml;
  logic [5:0] raw = 6'h00, ext = 6'h00, g;
  logic [3:0] warn = 4'h0, warn_st;
  logic [15:0] s;
  int errors = 0, n_checks = 0, c, b0;
  bgc_host_model i_host (.core_clk_i(clk), .rstn_i(rstn), .mode_i(mode), .raw_i(raw),
    .cmd_high_o(ch), .cmd_low_o(cml));
  bgc_gate_ctrl i_dut (.core_clk_i(clk), .rstn_i(rstn), .chip_enable_i(ce),
    .gate_cmd_high_i(ch), .gate_cmd_low_i(cml), .dead_time_select_i(dts),
    .blanking_select_i(bts), .short_threshold_select_i(thr),
    .switch_short_detect_enable_i(sc_en), .gate_bias_guard_enable_i(uv_en),
    .desat_high_i(dh), .desat_low_i(dl), .bias_low_i(bl), .current_limit_i(cl),
    .ext_fault_i(ext), .warn_i(warn), .high_gate_out_a_o(g[0]), .high_gate_out_b_o(g[1]),
    .high_gate_out_c_o(g[2]), .low_gate_out_a_o(g[3]), .low_gate_out_b_o(g[4]),
    .low_gate_out_c_o(g[5]), .fault_flag_out_o(fo), .fault_flag_oe_o(oe),
    .short_threshold_o(thr_o), .switch_uv_fault_o(uvf), .switch_short_fault_o(scf),
    .warn_status_o(warn_st));
  initial forever #50 clk = ~clk;
  always @(negedge clk) s <= {warn_st, thr_o, fo, scf, uvf, oe, g};
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rise(output int n);
    n = 0;
    while (s[5:0] == 6'h00 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("gate on", {7'h0, n < 200}, 8'h01);
  endtask
  task automatic ce_pulse;
    ce <= 1'b0;
    cyc(5);
    ce <= 1'b1;
    cyc(10);
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    end_of_test;
  end
  initial begin
    cyc(6);
    rstn <= 1'b1;
    cyc(3);
    chk("idle", s[7:0], 8'h00);
    for (int k = 0; k < 8; k++) begin
      dts <= 3'(k);
      cyc(5);
      raw <= 6'h01;
      rise(c);
      if (k == 0) b0 = c;
      chk("dead", 8'(c - b0), 8'(((k + 1) * 250 + 99) / 100 - 3));
      raw <= 6'h00;
      cyc(20);
    end
    for (int k = 0; k < 6; k++) begin
      raw <= 6'(1 << k);
      cyc(40);
      chk("map", {2'h0, s[5:0]}, 8'(1 << k));
      raw <= 6'h00;
      cyc(10);
    end
    raw <= 6'h01;
    cyc(40);
    raw <= 6'h08;
    cyc(40);
    chk("swap", {2'h0, s[5:0]}, 8'h08);
    raw <= 6'h09;
    cyc(10);
    chk("both", {2'h0, s[5:0]}, 8'h00);
    raw <= 6'h07;
    cyc(40);
    ce <= 1'b0;
    cyc(5);
    chk("ce", s[7:0], 8'h00);
    ce <= 1'b1;
    cyc(40);
    chk("ce back", s[7:0], 8'h07);
    for (int k = 0; k < 6; k++) begin
      ext <= 6'(1 << k);
      cyc(6);
      chk("ext", s[7:0], 8'h40);
      ext <= 6'h00;
      cyc(40);
      chk("ext off", s[7:0], 8'h07);
    end
    cl <= 1'b1;
    cyc(6);
    chk("ilim", s[7:0], 8'h47);
    cl <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      warn <= 4'(1 << k);
      cyc(6);
      chk("warn", {s[15:12], s[6], s[2:0]}, {4'(1 << k), 4'h7});
    end
    warn <= 4'h0;
    for (int k = 0; k < 4; k++) begin
      thr <= 2'(k);
      cyc(4);
      chk("thr", {6'h0, s[11:10]}, 8'(k));
    end
    raw <= 6'h00;
    cyc(10);
    for (int t = 0; t < 3; t++) begin
      sc_en <= (t < 2);
      dh <= {2'h0, t != 1};
      dl <= {2'h0, t == 1};
      raw <= (t == 1) ? 6'h0a : 6'h11;
      rise(c);
      cyc(30);
      chk("blank", {s[8], s[6], s[5:0]}, {2'h0, raw});
      cyc(30);
      chk("short", {s[8], s[6], s[5:0]}, (t < 2) ? 8'hc0 : {2'h0, raw});
      {dh, dl, raw} <= '0;
      cyc(5);
      ce_pulse;
      chk("clear", {7'h0, s[8]}, 8'h00);
    end
    sc_en <= 1'b1;
    bl <= 3'h7;
    cyc(200);
    chk("uv idle", {7'h0, s[7]}, 8'h00);
    for (int t = 0; t < 2; t++) begin
      uv_en <= (t == 0);
      bl <= 3'h7;
      raw <= 6'h01;
      rise(c);
      cyc(60);
      chk("uv early", {7'h0, s[7]}, 8'h00);
      cyc(80);
      chk("uv", s[7:0], (t == 0) ? 8'hc0 : 8'h01);
      raw <= 6'h00;
      bl <= 3'h0;
      cyc(5);
      ce_pulse;
      chk("uv clear", {7'h0, s[7]}, 8'h00);
    end
    dts <= 3'h0;
    uv_en <= 1'b1;
    mode <= 2'h1;
    cyc(40);
    chk("boot", {2'h0, s[5:0]}, 8'h38);
    mode <= 2'h2;
    cyc(40);
    chk("lock", {2'h0, s[5:0]}, 8'h15);
    mode <= 2'h3;
    cyc(600);
    mode <= 2'h0;
    cyc(10);
    end_of_test;
  end
endmodule
